// file: verilog/rco_consts.vh
// constants for the reference clock oscillator control block
// assumes a single sys_clk domain; oscillator and pins arrive asynchronously
`ifndef RCO_CONSTS_VH
`define RCO_CONSTS_VH

// reset values
`define RCO_OVERRIDE_RST 1'b0
`define RCO_FREQ_RST 1'b1
`define RCO_BUF_RST 1'b0

// field encodings
`define RCO_FREQ_36 1'b1
`define RCO_FREQ_26 1'b0
`define RCO_BUF_DIFF 1'b0
`define RCO_BUF_SE 1'b1
`define RCO_DRV_SE_CMOS 1'b1

// configuration pin decode table: {freq, buffer} per level
`define RCO_PIN_L0 2'b10
`define RCO_PIN_L1 2'b11
`define RCO_PIN_L2 2'b00
`define RCO_PIN_L3 2'b01
`define RCO_PIN_FREQ_BIT 1
`define RCO_PIN_BUF_BIT 0

// oscillator clocks counted in the boost phase
`define RCO_BOOST_CLOCKS 11'd1024

// reference divider ratios and half-ratios
`define RCO_DIV_36 8'd216
`define RCO_DIV_26 8'd156
`define RCO_HALF_36 8'd108
`define RCO_HALF_26 8'd78

`endif

// file: verilog/rco_top.v
// reference clock oscillator control: run/sleep, boost, divider, output buffers
// assumes the oscillator waveform and enable/config pins are asynchronous to
// sys_clk and are synchronised here; configuration bits come from sys_clk logic
`include "rco_consts.vh"
`timescale 1ns/1ps
`default_nettype none

module rco_top (
   // clock and reset
   input wire sys_clk,
   input wire rst,
   // pins
   input wire chip_enable,
   input wire [1:0] cfg_pin_level,
   input wire crystal_in,
   input wire ext_ref_mode,
   // configuration bits
   input wire power_down_request,
   input wire clock_cfg_override,
   input wire ref_freq_select,
   input wire out_buffer_select,
   input wire drive_level_select,
   input wire clock_out_disable,
   // oscillator core control
   output reg osc_bias_on,
   output reg osc_boost,
   output reg osc_running,
   output reg osc_buffer_only,
   output reg crystal_out,
   output reg core_clk_en,
   output reg chip_power_down,
   // effective selections
   output reg freq_36_eff,
   output reg buf_se_eff,
   // synthesizer reference
   output reg synth_ref_out,
   // clock output buffers
   output reg diff_buf_en,
   output reg diff_current_high,
   output reg se_buf_en,
   output reg se_cmos_mode,
   output reg ref_out_true,
   output reg ref_out_comp
);

   // synchronisers
   reg en_s1_q;
   reg en_s2_q;
   reg [1:0] lvl_s1_q;
   reg [1:0] lvl_s2_q;
   reg xin_s1_q;
   reg xin_s2_q;
   reg xin_prev_q;
   reg ext_s1_q;
   reg ext_s2_q;

   // internal state
   reg en_prev_q;
   reg [10:0] boost_cnt_q;
   reg [10:0] boost_cnt_d;
   reg boost_d;
   reg [7:0] div_cnt_q;
   reg [7:0] div_cnt_d;
   reg [1:0] pin_cfg;
   reg freq_d;
   reg buf_d;
   reg override_q;

   wire osc_edge;
   wire wake;
   wire [7:0] div_ratio;
   wire [7:0] div_half;

   // first stages feed only the second stages
   always @(posedge sys_clk) begin
      if (rst) begin
         en_s1_q <= 1'b0;
         en_s2_q <= 1'b0;
         lvl_s1_q <= 2'b00;
         lvl_s2_q <= 2'b00;
         xin_s1_q <= 1'b0;
         xin_s2_q <= 1'b0;
         ext_s1_q <= 1'b0;
         ext_s2_q <= 1'b0;
      end else begin
         en_s1_q <= chip_enable;
         en_s2_q <= en_s1_q;
         lvl_s1_q <= cfg_pin_level;
         lvl_s2_q <= lvl_s1_q;
         xin_s1_q <= crystal_in;
         xin_s2_q <= xin_s1_q;
         ext_s1_q <= ext_ref_mode;
         ext_s2_q <= ext_s1_q;
      end
   end

   // oscillator edge detect, only meaningful while running
   always @(posedge sys_clk) begin
      if (rst) begin
         xin_prev_q <= 1'b0;
         en_prev_q <= 1'b0;
      end else begin
         xin_prev_q <= xin_s2_q;
         en_prev_q <= en_s2_q;
      end
   end

   assign osc_edge = xin_s2_q & ~xin_prev_q & en_s2_q;
   assign wake = en_s2_q & ~en_prev_q;

   // run state follows enable; power-down request has no effect on it
   always @(posedge sys_clk) begin
      if (rst) begin
         osc_running <= 1'b0;
         osc_bias_on <= 1'b0;
         core_clk_en <= 1'b0;
      end else begin
         osc_running <= en_s2_q;
         osc_bias_on <= en_s2_q & ~ext_s2_q;
         core_clk_en <= en_s2_q;
      end
   end

   // chip power-down indication for the other blocks
   always @(posedge sys_clk) begin
      if (rst) begin
         chip_power_down <= 1'b0;
      end else begin
         chip_power_down <= en_s2_q & power_down_request;
      end
   end

   // an external reference is only buffered: no bias, no boost, no feedback drive
   always @(posedge sys_clk) begin
      if (rst) begin
         osc_buffer_only <= 1'b0;
         crystal_out <= 1'b0;
      end else begin
         osc_buffer_only <= ext_s2_q;
         crystal_out <= en_s2_q & ~ext_s2_q & ~xin_s2_q;
      end
   end

   // boost phase: count oscillator clocks, restart on every wake
   always @* begin
      boost_cnt_d = boost_cnt_q;
      boost_d = 1'b0;
      if (!en_s2_q || wake) begin
         boost_cnt_d = 11'd0;
         boost_d = en_s2_q & ~ext_s2_q;
      end else if (boost_cnt_q != `RCO_BOOST_CLOCKS) begin
         if (osc_edge) begin
            boost_cnt_d = boost_cnt_q + 11'd1;
         end
         boost_d = ~ext_s2_q;
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         boost_cnt_q <= 11'd0;
         osc_boost <= 1'b0;
      end else begin
         boost_cnt_q <= boost_cnt_d;
         osc_boost <= boost_d;
      end
   end

   // override bit held in its reset state until the first cycle after reset
   always @(posedge sys_clk) begin
      if (rst) begin
         override_q <= `RCO_OVERRIDE_RST;
      end else begin
         override_q <= clock_cfg_override;
      end
   end

   // configuration pin decode
   always @* begin
      pin_cfg = `RCO_PIN_L0;
      case (lvl_s2_q)
         2'd0: begin
            pin_cfg = `RCO_PIN_L0;
         end
         2'd1: begin
            pin_cfg = `RCO_PIN_L1;
         end
         2'd2: begin
            pin_cfg = `RCO_PIN_L2;
         end
         default: begin
            pin_cfg = `RCO_PIN_L3;
         end
      endcase
   end

   // override multiplexers
   always @* begin
      if (override_q) begin
         freq_d = ref_freq_select;
         buf_d = out_buffer_select;
      end else begin
         freq_d = pin_cfg[`RCO_PIN_FREQ_BIT];
         buf_d = pin_cfg[`RCO_PIN_BUF_BIT];
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         freq_36_eff <= `RCO_FREQ_RST;
         buf_se_eff <= `RCO_BUF_RST;
      end else begin
         freq_36_eff <= freq_d;
         buf_se_eff <= buf_d;
      end
   end

   // reference divider; ratio change takes effect at the next oscillator edge, a count at or above the new limit wraps
   assign div_ratio = (freq_36_eff == `RCO_FREQ_36) ? `RCO_DIV_36 : `RCO_DIV_26;
   assign div_half = (freq_36_eff == `RCO_FREQ_36) ? `RCO_HALF_36 : `RCO_HALF_26;

   always @* begin
      div_cnt_d = div_cnt_q;
      if (!en_s2_q) begin
         div_cnt_d = 8'd0;
      end else if (osc_edge) begin
         if (div_cnt_q >= div_ratio - 8'd1) begin
            div_cnt_d = 8'd0;
         end else begin
            div_cnt_d = div_cnt_q + 8'd1;
         end
      end
   end

   always @(posedge sys_clk) begin
      if (rst) begin
         div_cnt_q <= 8'd0;
         synth_ref_out <= 1'b0;
      end else begin
         div_cnt_q <= div_cnt_d;
         synth_ref_out <= en_s2_q & (div_cnt_d < div_half);
      end
   end

   // output buffers: exactly one style selected, both off when disabled or asleep
   always @(posedge sys_clk) begin
      if (rst) begin
         diff_buf_en <= 1'b0;
         se_buf_en <= 1'b0;
         diff_current_high <= 1'b0;
         se_cmos_mode <= 1'b0;
      end else begin
         diff_buf_en <= en_s2_q & ~clock_out_disable & (buf_d == `RCO_BUF_DIFF);
         se_buf_en <= en_s2_q & ~clock_out_disable & (buf_d == `RCO_BUF_SE);
         diff_current_high <= (buf_d == `RCO_BUF_DIFF) & drive_level_select;
         se_cmos_mode <= (buf_d == `RCO_BUF_SE) & (drive_level_select == `RCO_DRV_SE_CMOS);
      end
   end

   // reference clock pins; complement stays low in single-ended mode
   always @(posedge sys_clk) begin
      if (rst) begin
         ref_out_true <= 1'b0;
         ref_out_comp <= 1'b0;
      end else begin
         if (en_s2_q && !clock_out_disable) begin
            ref_out_true <= xin_s2_q;
            ref_out_comp <= (buf_d == `RCO_BUF_DIFF) & ~xin_s2_q;
         end else begin
            ref_out_true <= 1'b0;
            ref_out_comp <= 1'b0;
         end
      end
   end

endmodule

`default_nettype wire

// file: bench/rco_props.sv
// checker for rco_top: buffer exclusivity, selection muxes, run and sleep
// assumes binding to rco_top; one sys_clk domain, synchronous rst
`timescale 1ns/1ps
`default_nettype none
module rco_props (
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst,
   // pins and configuration
   input wire logic chip_enable,
   input wire logic [1:0] cfg_pin_level,
   input wire logic clock_cfg_override,
   input wire logic ref_freq_select,
   input wire logic out_buffer_select,
   input wire logic drive_level_select,
   input wire logic clock_out_disable,
   // outputs watched
   input wire logic osc_running,
   input wire logic osc_bias_on,
   input wire logic chip_power_down,
   input wire logic freq_36_eff,
   input wire logic buf_se_eff,
   input wire logic diff_buf_en,
   input wire logic se_buf_en,
   input wire logic diff_current_high,
   input wire logic se_cmos_mode
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   // pins take two sync stages plus the output register
   sequence en_held; chip_enable[*4]; endsequence
   sequence off_held; (!chip_enable)[*4]; endsequence
   sequence pin_held; (!clock_cfg_override && $stable(cfg_pin_level))[*6]; endsequence
   sequence ovr_held; (clock_cfg_override && $stable({ref_freq_select, out_buffer_select}))[*4];
   endsequence
   AST_ONE_BUF: assert property (!(diff_buf_en && se_buf_en)) else $error("both on");
   AST_RUN: assert property (en_held |-> osc_running) else $error("not running");
   AST_SLEEP: assert property (off_held |-> !osc_running && !osc_bias_on && !diff_buf_en &&
      !se_buf_en) else $error("awake");
   AST_PIN: assert property (pin_held |-> freq_36_eff == !cfg_pin_level[1] &&
      buf_se_eff == cfg_pin_level[0]) else $error("pin sel");
   AST_OVR: assert property (ovr_held |-> freq_36_eff == ref_freq_select &&
      buf_se_eff == out_buffer_select) else $error("ovr sel");
   AST_DIS: assert property (clock_out_disable |=> !diff_buf_en && !se_buf_en) else $error("dis");
   AST_PD: assert property (chip_power_down |-> osc_running) else $error("pd stop");
   AST_SE_DRV: assert property (se_buf_en && $past(se_buf_en) |->
      se_cmos_mode == $past(drive_level_select)) else $error("se drive");
   AST_DIFF_DRV: assert property (diff_buf_en && $past(diff_buf_en) |->
      diff_current_high == $past(drive_level_select)) else $error("diff drive");
endmodule
bind rco_top rco_props i_props (.*);
`default_nettype wire

// file: bench/rco_demod_model.sv
// demodulator model: counts rising edges arriving on both clock pins
// assumes pin clocks well below sys_clk/2
`timescale 1ns/1ps
`default_nettype none
module rco_demod_model (
   // clock
   input wire logic sys_clk,
   // reference clock pins
   input wire logic ref_true,
   input wire logic ref_comp,
   // edge counts
   output logic [15:0] n_true,
   output logic [15:0] n_comp
);
   logic t_q = 0;
   logic c_q = 0;
   // counters start at zero by declaration so each has a single driving process
   logic [15:0] cnt_true = 16'h0000;
   logic [15:0] cnt_comp = 16'h0000;
   assign n_true = cnt_true;
   assign n_comp = cnt_comp;
   always @(posedge sys_clk) begin
      t_q <= ref_true;
      c_q <= ref_comp;
      if (ref_true && !t_q) cnt_true <= cnt_true + 16'h0001;
      if (ref_comp && !c_q) cnt_comp <= cnt_comp + 16'h0001;
   end
endmodule
`default_nettype wire

// file: bench/tb_top.sv
// testbench for rco_top: boost, selection, disable, divider, sleep, ext ref
// assumes the demodulator model on the clock pins; 25 MHz sys_clk
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic sys_clk = 0, rst = 1, chip_enable = 0, crystal_in = 0, ext_ref_mode = 0;
   logic power_down_request = 0, clock_cfg_override = 0, ref_freq_select = 0, xen = 0;
   logic out_buffer_select = 0, drive_level_select = 0, clock_out_disable = 0, take = 0, b;
   logic [1:0] cfg_pin_level = 0, xc = 0;
   logic osc_bias_on, osc_boost, osc_running, osc_buffer_only, chip_power_down, freq_36_eff;
   logic buf_se_eff, synth_ref_out, diff_buf_en, diff_current_high, se_buf_en, se_cmos_mode;
   logic ref_out_true, ref_out_comp, crystal_out, core_clk_en;
   logic [15:0] n_true, n_comp;
   logic [8:0] e, exp_q[$];
   int fails = 0, checks = 0, cyc = 0, a, r, i;
   wire [8:0] obs = {freq_36_eff, buf_se_eff, diff_buf_en, se_buf_en, diff_current_high,
      se_cmos_mode, osc_running, osc_bias_on, chip_power_down};
   rco_top i_dut (.sys_clk, .rst, .chip_enable, .cfg_pin_level, .crystal_in, .ext_ref_mode,
      .power_down_request, .clock_cfg_override, .ref_freq_select, .out_buffer_select,
      .drive_level_select, .clock_out_disable, .osc_bias_on, .osc_boost, .osc_running,
      .osc_buffer_only, .crystal_out, .core_clk_en, .chip_power_down, .freq_36_eff,
      .buf_se_eff, .synth_ref_out, .diff_buf_en, .diff_current_high, .se_buf_en,
      .se_cmos_mode, .ref_out_true, .ref_out_comp);
   rco_demod_model i_demod (.sys_clk, .ref_true(ref_out_true), .ref_comp(ref_out_comp),
      .n_true, .n_comp);
   initial forever #20 sys_clk = ~sys_clk;
   // slow crystal, a quarter of sys_clk, so the sampled count cannot alias
   always @(posedge sys_clk) begin
      #1;
      xc = xc + 1'b1;
      crystal_in = xen & xc[1];
   end
   function automatic [8:0] ev(input f, bs, dis, drv, pd);
      ev = {f, bs, !dis & !bs, !dis & bs, !bs & drv, bs & drv, 1'b1, 1'b1, pd};
   endfunction
   task wrap_up;
      if (fails == 0 && checks > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask
   task chk(input logic [8:0] got, want);
      checks++;
      if (got !== want) begin
         fails++;
         $display("BAD %0t got %h want %h", $time, got, want);
      end
   endtask
   task note(input logic [8:0] v);
      exp_q.push_back(v);
      take = 1;
      @(posedge sys_clk);
      #1;
      take = 0;
   endtask
   task cfg(input [1:0] pin, input ovr, f, bs, drv, dis, pd);
      cfg_pin_level = pin;
      clock_cfg_override = ovr;
      ref_freq_select = f;
      out_buffer_select = bs;
      drive_level_select = drv;
      clock_out_disable = dis;
      power_down_request = pd;
      repeat (8) @(posedge sys_clk);
      #1;
   endtask
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         fails++;
         wrap_up;
      end
      if (take) begin
         e = exp_q.pop_front();
         checks++;
         if (obs !== e) begin
            fails++;
            $display("BAD %0t outputs %h want %h", $time, obs, e);
         end
      end
   end
   initial begin
      r = $urandom(40571);
      repeat (10) @(posedge sys_clk);
      #1;
      rst = 0;
      note(9'h100);
      chip_enable = 1;
      xen = 1;
      repeat (5) @(posedge sys_clk);
      #1;
      a = n_true;
      chk(9'(osc_boost), 9'd1);
      i = 0;
      while (osc_boost && i < 6000) begin
         @(posedge sys_clk);
         #1;
         i++;
      end
      chk(9'(n_true - a >= 1020 && n_true - a <= 1026), 9'd1);
      for (i = 0; i < 8; i++) begin
         r = $urandom;
         b = i[2] ? r[1] : i[0];
         cfg(i[1:0], i[2], r[0], r[1], r[2], 0, 0);
         note(ev(i[2] ? r[0] : !i[1], b, 0, r[2], 0));
         a = n_comp;
         repeat (20) @(posedge sys_clk);
         #1;
         chk(9'(n_comp != a), 9'(!b));
      end
      cfg(0, 0, 0, 0, 0, 1, 1);
      note(ev(1, 0, 1, 0, 1));
      for (i = 0; i < 2; i++) begin
         cfg(0, 1, i[0], 0, 0, 0, 0);
         repeat (2) @(posedge synth_ref_out);
         #1;
         a = n_true;
         @(posedge synth_ref_out);
         #1;
         chk(9'(n_true - a), i[0] ? 9'd216 : 9'd156);
         @(posedge sys_clk);
         #1;
      end
      chip_enable = 0;
      xen = 0;
      repeat (6) @(posedge sys_clk);
      #1;
      chk(9'({osc_running, osc_bias_on, ref_out_true, core_clk_en, crystal_out}), 9'd0);
      chip_enable = 1;
      xen = 1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk(9'(osc_boost), 9'd1);
      ext_ref_mode = 1;
      repeat (6) @(posedge sys_clk);
      #1;
      chk(9'({osc_buffer_only, osc_bias_on, osc_boost, osc_running, crystal_out, core_clk_en}),
         9'h25);
      wrap_up;
   end
endmodule
`default_nettype wire
